/* src/oad_pkg.sv */
`default_nettype none
package oad_pkg;
  // ----------------------------------------------------------------
  // Option-select field positions
  // ----------------------------------------------------------------
  localparam int OPT2_INST_LSB = 1;
  localparam int OPT2_INST_MSB = 3;
  localparam int OPT2_ROM_LSB  = 4;
  localparam int OPT2_ROM_MSB  = 7;
  localparam int OPT4_AP4_BIT  = 0;
  localparam int OPT4_VID_LSB  = 1;
  localparam int OPT4_VID_MSB  = 7;
  localparam int OPT5_AP1_LSB  = 0;
  localparam int OPT5_AP1_MSB  = 3;
  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  localparam int          ROM_STEP_SHIFT   = 13;            // 0x2000 per step
  localparam logic [31:0] ROM_ORIGIN       = 32'h000C0000;
  localparam int          COP_STRIDE_SHIFT = 7;             // 128 per instance
  localparam logic [31:0] COP_OFFSET       = 32'h00001C00;
  localparam logic [7:0]  IO_PREFIX        = 8'h21;
  localparam int          VID_REGION_SHIFT = 25;            // 32MB region
  localparam int          VID_SLICE_SHIFT  = 22;            // 4MB slice
  localparam int          AP1_SHIFT        = 20;            // 1MB
  // Window sizes as log2 of bytes
  localparam int          ROM_WIN_LOG2     = 13;
  localparam int          COP_WIN_LOG2     = 7;
  localparam int          IO_WIN_LOG2      = 4;
  // ----------------------------------------------------------------
  // Indexed display registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  DISP_ID_INDEX    = 8'h52;
  localparam int          MODE_COMPAT_BIT  = 0;
  localparam int          MODE_TEXT132_BIT = 2;
  localparam logic [3:0]  DISP_ID_RESET    = 4'hF;          // No monitor code

  typedef struct packed {
    logic        live;
    logic        ap4_en;
    logic        ap1_en;
    logic [2:0]  inst;
    logic [31:0] rom_base;
    logic [31:0] cop_base;
    logic [15:0] io_base;
    logic [31:0] vid_base;
    logic [31:0] ap1_base;
  } oad_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [31:0] addr;
  } oad_req_t;

  typedef struct packed {
    logic rom;
    logic cop;
    logic io;
    logic ap4;
    logic ap1;
  } oad_sel_t;
endpackage
`default_nettype wire

/* src/oad_decoder.sv */
`default_nettype none
module oad_decoder (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [7:0]       opt2,
  input  wire logic [7:0]       opt4,
  input  wire logic [7:0]       opt5,
  input  wire oad_pkg::oad_req_t host_req,
  output logic                  claim,
  output oad_pkg::oad_sel_t     claim_sel,
  output oad_pkg::oad_sel_t     last_sel_q,
  input  wire logic [31:0]      cop_addr,
  output logic                  cop_local,
  output logic [31:0]           vid_base_q,
  input  wire logic [3:0]       monitor_id_pin,
  input  wire logic             compat_mode_en,
  input  wire logic             text132_mode_en,
  input  wire logic [7:0]       disp_index,
  output logic [7:0]            disp_data_q,
  output logic [7:0]            op_mode_q
);

  // ----------------------------------------------------------------
  // Range compare helper
  // ----------------------------------------------------------------
  function automatic logic in_win(input logic [31:0] a, input logic [31:0] base,
                                  input int log2sz);
    logic [31:0] mask;
    mask   = ~((32'h00000001 << log2sz) - 32'h00000001);
    in_win = (a & mask) == (base & mask);
  endfunction

  // ----------------------------------------------------------------
  // Base computation, refreshed every cycle from the option fields
  // ----------------------------------------------------------------
  oad_pkg::oad_cfg_t cfg_q;
  oad_pkg::oad_cfg_t cfg_d;
  logic [2:0]        inst;
  logic [3:0]        rom_fld;
  logic [6:0]        vid_fld;
  logic [3:0]        ap1_fld;

  always_comb
  begin
    inst    = opt2[oad_pkg::OPT2_INST_MSB:oad_pkg::OPT2_INST_LSB];
    rom_fld = opt2[oad_pkg::OPT2_ROM_MSB:oad_pkg::OPT2_ROM_LSB];
    vid_fld = opt4[oad_pkg::OPT4_VID_MSB:oad_pkg::OPT4_VID_LSB];
    ap1_fld = opt5[oad_pkg::OPT5_AP1_MSB:oad_pkg::OPT5_AP1_LSB];
    cfg_d          = '0;
    cfg_d.live     = 1'b1;
    cfg_d.inst     = inst;
    cfg_d.rom_base = (32'(rom_fld) << oad_pkg::ROM_STEP_SHIFT) + oad_pkg::ROM_ORIGIN;
    cfg_d.cop_base = (32'(inst) << oad_pkg::COP_STRIDE_SHIFT) + oad_pkg::COP_OFFSET
                     + cfg_d.rom_base;
    cfg_d.io_base  = {oad_pkg::IO_PREFIX, 1'b0, inst, 4'h0};
    // Full 32 bits even when the host slot is narrower
    cfg_d.vid_base = (32'(vid_fld) << oad_pkg::VID_REGION_SHIFT)
                     | (32'(inst) << oad_pkg::VID_SLICE_SHIFT);
    cfg_d.ap4_en   = opt4[oad_pkg::OPT4_AP4_BIT];
    cfg_d.ap1_en   = ap1_fld != 4'h0;
    cfg_d.ap1_base = 32'(ap1_fld) << oad_pkg::AP1_SHIFT;
  end

  // One cycle of latency after an option write; no claims until first load
  always_ff @(posedge clock)
  begin
    if (rst)
      cfg_q <= '0;
    else
      cfg_q <= cfg_d;
  end

  assign vid_base_q = cfg_q.vid_base;

  // ----------------------------------------------------------------
  // Host claim decode, same cycle as the request
  // ----------------------------------------------------------------
  always_comb
  begin
    claim_sel = '0;
    if (host_req.valid && cfg_q.live)
    begin
      if (host_req.is_io)
        claim_sel.io = in_win({16'h0000, host_req.addr[15:0]}, {16'h0000, cfg_q.io_base},
                              oad_pkg::IO_WIN_LOG2);
      else
      begin
        // Coprocessor block lies inside the ROM window and takes precedence
        claim_sel.cop = in_win(host_req.addr, cfg_q.cop_base, oad_pkg::COP_WIN_LOG2);
        claim_sel.rom = !claim_sel.cop
                        && in_win(host_req.addr, cfg_q.rom_base, oad_pkg::ROM_WIN_LOG2);
        claim_sel.ap4 = cfg_q.ap4_en
                        && in_win(host_req.addr, cfg_q.vid_base,
                                  oad_pkg::VID_SLICE_SHIFT);
        claim_sel.ap1 = cfg_q.ap1_en
                        && in_win(host_req.addr, cfg_q.ap1_base, oad_pkg::AP1_SHIFT);
      end
    end
    claim = |claim_sel;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      last_sel_q <= '0;
    else if (claim)
      last_sel_q <= claim_sel;
  end

  // Aperture enable does not matter to the coprocessor's view
  assign cop_local = cfg_q.live
                     && in_win(cop_addr, cfg_q.vid_base, oad_pkg::VID_SLICE_SHIFT);

  // ----------------------------------------------------------------
  // Display identification and mode reporting
  // ----------------------------------------------------------------
  logic [3:0] mon_meta_q;
  logic [3:0] mon_sync_q;

  // Monitor sense pins are asynchronous
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mon_meta_q <= oad_pkg::DISP_ID_RESET;
      mon_sync_q <= oad_pkg::DISP_ID_RESET;
    end
    else
    begin
      mon_meta_q <= monitor_id_pin;
      mon_sync_q <= mon_meta_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      disp_data_q <= 8'h00;
    else if (disp_index == oad_pkg::DISP_ID_INDEX)
      disp_data_q <= {4'h0, mon_sync_q};
    else
      disp_data_q <= 8'h00;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      op_mode_q <= 8'h00;
    else
    begin
      op_mode_q                            <= 8'h00;
      op_mode_q[oad_pkg::MODE_COMPAT_BIT]  <= compat_mode_en;
      op_mode_q[oad_pkg::MODE_TEXT132_BIT] <= text132_mode_en;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ROM_BASE: assert property (@(posedge clock) disable iff (rst)
    cfg_q.live |-> cfg_q.rom_base == (32'({$past(opt2[7:4])}) * 32'h00002000 + 32'h000C0000))
    else $error("rom base wrong");

  AST_COP_BASE: assert property (@(posedge clock) disable iff (rst)
    cfg_q.live |-> cfg_q.cop_base == cfg_q.rom_base + 32'h00001C00
                   + 32'(cfg_q.inst) * 32'h00000080)
    else $error("coprocessor base wrong");

  AST_INST: assert property (@(posedge clock) disable iff (rst)
    !rst |=> cfg_q.inst == $past(opt2[3:1]))
    else $error("instance not taken from option bits");

  AST_IO_HIT: assert property (@(posedge clock) disable iff (rst)
    (cfg_q.live && host_req.valid && host_req.is_io
     && host_req.addr[15:4] == {8'h21, 1'b0, cfg_q.inst}) |-> claim && claim_sel.io)
    else $error("io block not claimed");

  AST_VID_BASE: assert property (@(posedge clock) disable iff (rst)
    cfg_q.live |-> vid_base_q[31:22] == {$past(opt4[7:1]), $past(opt2[3:1])}
                   && vid_base_q[21:0] == 22'h000000)
    else $error("video base wrong");

  AST_AP4_OFF: assert property (@(posedge clock) disable iff (rst)
    !cfg_q.ap4_en |-> !claim_sel.ap4)
    else $error("4MB aperture claimed while disabled");

  AST_AP4_HIT: assert property (@(posedge clock) disable iff (rst)
    (cfg_q.live && cfg_q.ap4_en && host_req.valid && !host_req.is_io
     && host_req.addr[31:22] == vid_base_q[31:22]) |-> claim && claim_sel.ap4)
    else $error("4MB aperture not claimed");

  AST_COP_LOCAL: assert property (@(posedge clock) disable iff (rst)
    cfg_q.live |-> cop_local == (cop_addr[31:22] == vid_base_q[31:22]))
    else $error("local video decision wrong");

  AST_AP1: assert property (@(posedge clock) disable iff (rst)
    claim_sel.ap1 |-> $past(opt5[3:0]) != 4'h0 && host_req.addr[31:20] == 12'($past(opt5[3:0])))
    else $error("1MB aperture decode wrong");

  AST_DISP_ID: assert property (@(posedge clock) disable iff (rst)
    (disp_index == 8'h52) ##1 !rst |-> disp_data_q[3:0] == $past(mon_sync_q))
    else $error("display id not returned");

  AST_MODE: assert property (@(posedge clock) disable iff (rst)
    ##1 1'b1 |-> op_mode_q[0] == $past(compat_mode_en) && op_mode_q[2] == $past(text132_mode_en))
    else $error("mode bits wrong");

  AST_CLAIM_VALID: assert property (@(posedge clock) disable iff (rst)
    claim |-> host_req.valid && cfg_q.live)
    else $error("claim without request");

  COV_IO:   cover property (@(posedge clock) disable iff (rst) claim_sel.io);
  COV_COP:  cover property (@(posedge clock) disable iff (rst) claim_sel.cop);
  COV_AP4:  cover property (@(posedge clock) disable iff (rst) claim_sel.ap4);
  COV_AP1:  cover property (@(posedge clock) disable iff (rst) claim_sel.ap1);
  COV_ROM:  cover property (@(posedge clock) disable iff (rst) claim_sel.rom);

endmodule
`default_nettype wire

/* bench/oad_host_model.sv */
`default_nettype none
module oad_host_model (
  input  wire logic              clock,
  input  wire oad_pkg::oad_req_t cmd,
  output oad_pkg::oad_req_t      host_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_req = '0;
  // Idle bus shows the inverse of the last cycle, so a stale address comes back every second idle cycle, with valid low
  always @(posedge clock)
  begin
    if (cmd.valid)
      host_req <= cmd;
    else
      host_req <= '{valid: 1'b0, is_io: ~host_req.is_io, addr: ~host_req.addr};
  end
endmodule
`default_nettype wire

/* bench/option_address_decoder_tb.sv */
`default_nettype none
module option_address_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic [7:0]        opt2 = 8'h00, opt4 = 8'h00, opt5 = 8'h00, disp_index = 8'h00;
  logic [31:0]       cop_addr = 32'h0, vid_base_q;
  logic [3:0]        monitor_id_pin = 4'hF;
  logic              compat_mode_en = 1'b0, text132_mode_en = 1'b0, claim, cop_local;
  logic [7:0]        disp_data_q, op_mode_q;
  oad_pkg::oad_req_t cmd = '0, host_req;
  oad_pkg::oad_sel_t claim_sel, last_sel_q;
  int                n_errors = 0, samples_checked = 0;

  always #4 clock = ~clock;

  oad_host_model host (.clock, .cmd, .host_req);
  oad_decoder dut (.clock, .rst, .opt2, .opt4, .opt5, .host_req, .claim, .claim_sel,
    .last_sel_q, .cop_addr, .cop_local, .vid_base_q, .monitor_id_pin, .compat_mode_en,
    .text132_mode_en, .disp_index, .disp_data_q, .op_mode_q);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_sel(input oad_pkg::oad_sel_t got, input oad_pkg::oad_sel_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t select %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cfg(input logic [7:0] o2, input logic [7:0] o4, input logic [7:0] o5);
    @(posedge clock);
    opt2 <= o2;
    opt4 <= o4;
    opt5 <= o5;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Claim is combinational, so it is sampled in the cycle the host cycle stands
  task automatic hit(input logic io, input logic [31:0] a, input logic [4:0] s);
    @(posedge clock);
    cmd <= '{valid: 1'b1, is_io: io, addr: a};
    @(posedge clock);
    cmd <= '0;
    #1;
    chk(claim, {31'h0, |s});
    chk_sel(claim_sel, s);
    @(posedge clock);
    #1;
    if (|s)
      chk_sel(last_sel_q, s);
  endtask

  task automatic loc(input logic [31:0] a, input logic e);
    @(posedge clock);
    cop_addr <= a;
    @(posedge clock);
    #1;
    chk(cop_local, {31'h0, e});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_rom_cop;
    cfg(8'h3C, 8'h00, 8'h00);
    hit(1'b0, 32'h000C6000, 5'h10);
    hit(1'b0, 32'h000C7F00, 5'h08);
    hit(1'b0, 32'h000C7F7F, 5'h08);
    hit(1'b0, 32'h000C7F80, 5'h10);
    hit(1'b0, 32'h000C8000, 5'h00);
    hit(1'b0, 32'h000C5FFF, 5'h00);
    cfg(8'hF0, 8'h00, 8'h00);
    hit(1'b0, 32'h000DE000, 5'h10);
    $display("t_rom_cop done");
  endtask

  task automatic t_inst;
    for (int i = 0; i < 8; i++)
    begin
      cfg({4'h0, i[2:0], 1'b0}, 8'h03, 8'h00);
      hit(1'b0, 32'h000C1C00 + 32'(i) * 32'h80, 5'h08);
      hit(1'b1, {16'hFFFF, 8'h21, 1'b0, i[2:0], 4'h0}, 5'h04);
      hit(1'b1, {16'h0000, 8'h21, 1'b0, i[2:0], 4'hF}, 5'h04);
      chk(vid_base_q, {7'h01, i[2:0], 22'h0});
    end
    hit(1'b1, 32'h00002160, 5'h00);
    hit(1'b0, 32'h00002170, 5'h00);
    $display("t_inst done");
  endtask

  task automatic t_vid;
    cfg(8'h0C, 8'h03, 8'h00);
    chk(vid_base_q, 32'h03800000);
    hit(1'b0, 32'h03800000, 5'h02);
    hit(1'b0, 32'h03BFFFFF, 5'h02);
    hit(1'b0, 32'h03C00000, 5'h00);
    cfg(8'h0C, 8'hFE, 8'h00);
    chk(vid_base_q, 32'hFF800000);
    hit(1'b0, 32'hFF800000, 5'h00);
    loc(32'hFF800000, 1'b1);
    loc(32'hFFBFFFFF, 1'b1);
    loc(32'hFF7FFFFF, 1'b0);
    loc(32'hFFC00000, 1'b0);
    $display("t_vid done");
  endtask

  task automatic t_ap1;
    cfg(8'h00, 8'h00, 8'h00);
    hit(1'b0, 32'h00000100, 5'h00);
    cfg(8'h00, 8'h00, 8'h05);
    hit(1'b0, 32'h00500000, 5'h01);
    hit(1'b0, 32'h005FFFFF, 5'h01);
    hit(1'b0, 32'h00600000, 5'h00);
    hit(1'b0, 32'h004FFFFF, 5'h00);
    $display("t_ap1 done");
  endtask

  task automatic t_disp;
    @(posedge clock);
    disp_index <= 8'h52;
    repeat (2) @(posedge clock);
    #1;
    chk(disp_data_q, 32'h0F);
    @(posedge clock);
    monitor_id_pin <= 4'hA;
    disp_index <= 8'h52;
    compat_mode_en <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    chk(disp_data_q, 32'h0A);
    chk(op_mode_q, 32'h01);
    @(posedge clock);
    disp_index <= 8'h51;
    compat_mode_en <= 1'b0;
    text132_mode_en <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk(disp_data_q, 32'h00);
    chk(op_mode_q, 32'h04);
    $display("t_disp done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk(claim, 32'h0);
    chk(op_mode_q, 32'h0);
    t_rom_cop;
    t_inst;
    t_vid;
    t_ap1;
    t_disp;
    close_out;
  end

  // Whole sequence needs well under 2000 cycles
  initial
  begin
    #200000;
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire
